// File: rtl/atc_pkg.sv
package atc_pkg;
    // register map, word addresses on the plain port
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_LEVEL = 4'h1;
    localparam logic [3:0] ADDR_VETO = 4'h2;
    localparam logic [3:0] ADDR_TIMEOUT = 4'h3;
    localparam logic [3:0] ADDR_RATE = 4'h4;
    localparam logic [3:0] ADDR_LED = 4'h5;
    localparam logic [3:0] ADDR_STATUS = 4'h6;
    localparam logic [3:0] ADDR_CMD = 4'h7;
    // control fields
    localparam int CTRL_SRC_LSB = 0;
    localparam int CTRL_CPL_LSB = 2;
    localparam int CTRL_NEG = 4;
    localparam int CTRL_WIN = 5;
    localparam int CTRL_WIN_ENTER = 6;
    localparam int CTRL_BUFFERED = 7;
    localparam int CTRL_TMO_EN = 8;
    localparam int CTRL_PREP_SEL = 9;
    localparam int CTRL_SINGLE = 10;
    localparam int CTRL_EXTFS_LSB = 11;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // command bits
    localparam int CMD_ARM = 0;
    localparam int CMD_FORCE = 1;
    localparam int CMD_READOUT_DONE = 2;
    localparam int CMD_DISARM = 3;
    // led override register
    localparam int LED_OVR = 0;
    localparam int LED_COLOR_LSB = 1;
    localparam logic [1:0] LED_OFF = 2'h0;
    localparam logic [1:0] LED_GREEN = 2'h1;
    localparam logic [1:0] LED_RED = 2'h2;
    // sources and couplings
    localparam logic [1:0] SRC_CH0 = 2'h0;
    localparam logic [1:0] SRC_CH1 = 2'h1;
    localparam logic [1:0] SRC_EXT = 2'h2;
    localparam logic [1:0] CPL_DC = 2'h0;
    localparam logic [1:0] CPL_AC = 2'h1;
    localparam logic [1:0] CPL_HFREJ = 2'h2;
    localparam logic [1:0] CPL_HF = 2'h3;
    // level limits, 8 bit signed codes; half full scale is +-128 codes
    localparam logic signed [7:0] LEVEL_MIN = 8'sh80;
    localparam logic signed [7:0] LEVEL_MAX = 8'sh7f;
    localparam logic [7:0] SAMPLE_MIN_CODE = 8'h80;
    localparam int HF_EDGE_COUNT = 4;
    // sampling rate table: mantissa index 0..4 and decade 2..9 (100 S/s..)
    localparam logic [2:0] RATE_MANT_MAX = 3'h4;
    localparam logic [3:0] RATE_DEC_MIN = 4'h2;
    localparam logic [3:0] RATE_DEC_MAX = 4'h9;
    // veto and timeout: 30 ns steps, up to 1 s
    localparam int VETO_STEP_NS = 30;
    localparam int VETO_MAX_NS = 1000000000;
    localparam int VETO_STEPS_MAX = VETO_MAX_NS / VETO_STEP_NS;
    localparam int CLK_PERIOD_NS = 20;
    // 30 ns at 20 ns clock: fractional, so ticks accumulate in ns
    localparam int ACQ_CYCLES_DEF = 64;
    typedef enum logic [2:0] {
        ATC_IDLE, ATC_READY, ATC_VETO, ATC_OPEN, ATC_ACQ, ATC_DONE
    } atc_state_e;
endpackage : atc_pkg

// File: rtl/atc_trigger.sv
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module atc_trigger
    import atc_pkg::*;
#(
    parameter int ACQ_CYCLES = ACQ_CYCLES_DEF,
    parameter bit SINGLE_INPUT = 1'b0,
    parameter int RATE_DEC_TOP = 9
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic signed [7:0] i_ch0,
    input wire logic signed [7:0] i_ch1,
    input wire logic signed [7:0] i_ext,
    input wire logic i_prep_a,
    input wire logic i_prep_b,
    output logic o_trig_out,
    output logic o_acquisition_ready_out,
    output logic [1:0] o_led,
    output logic [7:0] o_sample,
    output logic o_sample_valid,
    output logic [2:0] o_rate_mant,
    output logic [3:0] o_rate_dec
);
    // all state in one record: one comb process builds the next
    // copy, one register stage loads it, so every output below
    // comes straight from a flip-flop
    typedef struct packed {
        atc_state_e state;
        logic [31:0] ctrl;
        logic signed [7:0] lvl_lo;
        logic signed [7:0] lvl_hi;
        logic [24:0] veto;
        logic [24:0] tmo;
        logic [2:0] rate_mant;
        logic [3:0] rate_dec;
        logic [2:0] led;
        logic [31:0] rdata;
        logic [1:0] pa_sync;
        logic [1:0] pb_sync;
        logic prep_prev;
        logic signed [7:0] prev;
        logic [1:0] hf_cnt;
        logic [31:0] ns_acc;
        logic [24:0] steps;
        logic [31:0] acq_cnt;
        logic artificial;
        logic trig_out;
        logic ready;
        logic [1:0] led_out;
        logic [7:0] sample;
        logic sample_valid;
        logic signed [7:0] auto_min;
        logic signed [7:0] auto_max;
    } atc_s;

    // registered state and the value the next edge loads
    atc_s r;
    atc_s next_r;

    // trigger path helpers, decoded from r and the inputs;
    // no extra pipeline, so a crossing costs one cycle only
    logic signed [7:0] src;
    logic signed [7:0] lvl;
    logic signed [8:0] mid;
    logic rise_cross;
    logic fall_cross;
    logic edge_hit;
    logic hw_trig;
    logic prep_pulse;
    logic [1:0] cpl;
    logic step_tick;

    // source mux and edge detection
    // the previous sample is registered, so a crossing needs two
    // samples on opposite sides of the level; landing exactly on
    // the level from below still counts as a rise
    // switching the source can itself look like a crossing, so
    // reconfigure only while the block is idle
    always_comb begin
        cpl = r.ctrl[CTRL_CPL_LSB +: 2];
        case (r.ctrl[CTRL_SRC_LSB +: 2])
            SRC_CH0: src = i_ch0;
            SRC_CH1: src = i_ch1;
            default: src = i_ext;
        endcase
        // auto level: midpoint of observed extremes
        mid = (9'(r.auto_min) + 9'(r.auto_max)) >>> 1;
        if (SINGLE_INPUT && cpl == CPL_AC) begin
            lvl = mid[7:0];
        end else begin
            lvl = r.lvl_lo;
        end
        rise_cross = (r.prev < lvl) && (src >= lvl);
        fall_cross = (r.prev >= lvl) && (src < lvl);
        // window: or of two edge detectors of opposite slope, one
        // per threshold; hf coupling blocks it even if a stale
        // control word still carries the window bit
        if (r.ctrl[CTRL_WIN] && cpl != CPL_HF) begin
            // exit: rise over hi or fall under lo; entry the opposite
            if (r.ctrl[CTRL_WIN_ENTER]) begin
                edge_hit = ((r.prev >= r.lvl_hi) && (src < r.lvl_hi))
                    || ((r.prev < r.lvl_lo) && (src >= r.lvl_lo));
            end else begin
                edge_hit = ((r.prev < r.lvl_hi) && (src >= r.lvl_hi))
                    || ((r.prev >= r.lvl_lo) && (src < r.lvl_lo));
            end
        end else if (r.ctrl[CTRL_NEG] && cpl != CPL_HF) begin
            edge_hit = fall_cross;
        end else begin
            edge_hit = rise_cross;
        end
        // hf mode divides rising crossings by four; the divider runs
        // free, so the first trigger after arming may come early
        if (cpl == CPL_HF) begin
            hw_trig = rise_cross
                && (r.hf_cnt == 2'(HF_EDGE_COUNT - 1));
        end else begin
            hw_trig = edge_hit;
        end
        // prepare edge seen only behind the two-stage synchroniser;
        // a pin switch can fake one edge, harmless outside ready
        // where prepare is ignored anyway
        prep_pulse = (r.ctrl[CTRL_PREP_SEL] ? r.pb_sync[1] : r.pa_sync[1])
            && !r.prep_prev;
        // 20 ns cannot hit 30 ns exactly: two ticks every three
        // cycles, so a step boundary jitters by one cycle
        step_tick = (r.ns_acc + 32'(CLK_PERIOD_NS)) >= 32'(VETO_STEP_NS);
    end

    // next-state logic for the whole block
    // defaults first: synchronisers and previous sample shift,
    // pulses drop after one cycle, read data goes back to zero,
    // everything else holds unless a branch below decides otherwise
    always_comb begin
        next_r = r;
        next_r.pa_sync = {r.pa_sync[0], i_prep_a};
        next_r.pb_sync = {r.pb_sync[0], i_prep_b};
        next_r.prep_prev = r.ctrl[CTRL_PREP_SEL] ? r.pb_sync[1]
            : r.pa_sync[1];
        next_r.prev = src;
        next_r.trig_out = 1'b0;
        next_r.sample_valid = 1'b0;
        next_r.rdata = 32'h0000_0000;
        // the divider counts even while idle
        if (cpl == CPL_HF && rise_cross) begin
            next_r.hf_cnt = r.hf_cnt + 2'h1;
        end
        // running extremes for the automatic level; a control write
        // restarts them so an old signal cannot bias the level
        if (src < r.auto_min) begin
            next_r.auto_min = src;
        end
        if (src > r.auto_max) begin
            next_r.auto_max = src;
        end
        // register writes
        // a write lands at the edge that samples the strobe; the
        // slave never stalls, so bad values are clipped or dropped
        if (i_wr) begin
            if (i_addr == ADDR_CTRL) begin
                next_r.ctrl = i_wdata;
                // hf coupling cannot keep slope or window bits
                if (i_wdata[CTRL_CPL_LSB +: 2] == CPL_HF) begin
                    next_r.ctrl[CTRL_NEG] = 1'b0;
                    next_r.ctrl[CTRL_WIN] = 1'b0;
                end
                // the unused source code falls back to external
                if (i_wdata[CTRL_SRC_LSB +: 2] == 2'h3) begin
                    next_r.ctrl[CTRL_SRC_LSB +: 2] = SRC_EXT;
                end
                next_r.auto_min = LEVEL_MAX;
                next_r.auto_max = LEVEL_MIN;
            end else if (i_addr == ADDR_LEVEL) begin
                // codes span midpoint +- half full scale, so any 8-bit
                // value is already in range for both source kinds
                next_r.lvl_lo = i_wdata[7:0];
                next_r.lvl_hi = i_wdata[15:8];
            end else if (i_addr == ADDR_VETO) begin
                next_r.veto = (i_wdata[24:0] > 25'(VETO_STEPS_MAX))
                    ? 25'(VETO_STEPS_MAX) : i_wdata[24:0];
            end else if (i_addr == ADDR_TIMEOUT) begin
                next_r.tmo = (i_wdata[24:0] > 25'(VETO_STEPS_MAX))
                    ? 25'(VETO_STEPS_MAX) : i_wdata[24:0];
            end else if (i_addr == ADDR_RATE) begin
                if (i_wdata[2:0] <= RATE_MANT_MAX
                    && i_wdata[7:4] >= RATE_DEC_MIN
                    && i_wdata[7:4] <= 4'(RATE_DEC_TOP)) begin
                    next_r.rate_mant = i_wdata[2:0];
                    next_r.rate_dec = i_wdata[7:4];
                end
            end else if (i_addr == ADDR_LED) begin
                next_r.led = i_wdata[2:0];
            end
        end
        // register reads, data in the following cycle
        // unmapped addresses and the command word read zero
        if (i_rd) begin
            if (i_addr == ADDR_CTRL) begin
                next_r.rdata = r.ctrl;
            end else if (i_addr == ADDR_LEVEL) begin
                next_r.rdata = {16'h0000, r.lvl_hi, r.lvl_lo};
            end else if (i_addr == ADDR_VETO) begin
                next_r.rdata = {7'h00, r.veto};
            end else if (i_addr == ADDR_TIMEOUT) begin
                next_r.rdata = {7'h00, r.tmo};
            end else if (i_addr == ADDR_RATE) begin
                next_r.rdata = {24'h000000, r.rate_dec, 1'b0, r.rate_mant};
            end else if (i_addr == ADDR_LED) begin
                next_r.rdata = {29'h0, r.led};
            end else if (i_addr == ADDR_STATUS) begin
                next_r.rdata = {25'h0, r.artificial, r.ready,
                    5'(r.state)} & 32'h0000_007f;
            end
        end
        // veto and timeout step counter, 30 ns units from 20 ns clock
        // one counter serves both phases and restarts at each phase
        // change, so a long veto cannot shorten the timeout
        if (r.state == ATC_VETO || r.state == ATC_OPEN) begin
            if (step_tick) begin
                next_r.ns_acc = r.ns_acc + 32'(CLK_PERIOD_NS)
                    - 32'(VETO_STEP_NS);
                next_r.steps = r.steps + 25'h1;
            end else begin
                next_r.ns_acc = r.ns_acc + 32'(CLK_PERIOD_NS);
            end
        end
        // acquisition sequencer
        // ready is a level from arming until any kind of trigger;
        // every path into acquisition clears it in that cycle
        case (r.state)
            // idle until software arms the block
            ATC_IDLE: begin
                next_r.ready = 1'b0;
                if (i_wr && i_addr == ADDR_CMD && i_wdata[CMD_ARM]) begin
                    next_r.state = ATC_READY;
                    next_r.ready = 1'b1;
                end
            end
            // non-buffered mode takes the first valid trigger
            ATC_READY: begin
                // buffered mode waits for prepare, itself only seen now
                if (r.ctrl[CTRL_BUFFERED] && prep_pulse) begin
                    next_r.state = ATC_VETO;
                    next_r.steps = 25'h0;
                    next_r.ns_acc = 32'h0;
                end else if (!r.ctrl[CTRL_BUFFERED] && hw_trig) begin
                    next_r.trig_out = 1'b1;
                    next_r.ready = 1'b0;
                    next_r.artificial = 1'b0;
                    next_r.acq_cnt = 32'h0;
                    next_r.state = ATC_ACQ;
                end
            end
            // the veto runs its full length whatever the source does
            ATC_VETO: begin
                // hw triggers simply fall through here
                if (r.steps >= r.veto) begin
                    next_r.state = ATC_OPEN;
                    next_r.steps = 25'h0;
                    next_r.ns_acc = 32'h0;
                end
            end
            // a real trigger wins over a timeout in the same cycle
            ATC_OPEN: begin
                if (hw_trig) begin
                    next_r.trig_out = 1'b1;
                    next_r.ready = 1'b0;
                    next_r.artificial = 1'b0;
                    next_r.acq_cnt = 32'h0;
                    next_r.state = ATC_ACQ;
                end else if (r.ctrl[CTRL_TMO_EN] && r.steps >= r.tmo) begin
                    next_r.ready = 1'b0;
                    next_r.artificial = 1'b1;
                    next_r.acq_cnt = 32'h0;
                    next_r.state = ATC_ACQ;
                end
            end
            // real and artificial bursts share this counter, so
            // both last exactly ACQ_CYCLES samples
            ATC_ACQ: begin
                next_r.ready = 1'b0;
                next_r.sample_valid = 1'b1;
                next_r.sample = r.artificial ? SAMPLE_MIN_CODE
                    : 8'(src);
                next_r.acq_cnt = r.acq_cnt + 32'h1;
                if (r.acq_cnt == 32'(ACQ_CYCLES - 1)) begin
                    next_r.state = ATC_DONE;
                end
            end
            // data waits here until software reports the readout
            ATC_DONE: begin
                if (i_wr && i_addr == ADDR_CMD
                    && i_wdata[CMD_READOUT_DONE]) begin
                    next_r.state = ATC_IDLE;
                end
            end
            default: next_r.state = ATC_IDLE;
        endcase
        // software force: no trigger output pulse
        // a force beats a hardware trigger in the same cycle, so a
        // forced acquisition never shows an output pulse
        if (i_wr && i_addr == ADDR_CMD && i_wdata[CMD_FORCE]
            && (r.state == ATC_READY || r.state == ATC_OPEN)) begin
            next_r.trig_out = 1'b0;
            next_r.ready = 1'b0;
            next_r.artificial = 1'b0;
            next_r.acq_cnt = 32'h0;
            next_r.state = ATC_ACQ;
        end
        // disarm has the last word over every other command
        if (i_wr && i_addr == ADDR_CMD && i_wdata[CMD_DISARM]) begin
            next_r.state = ATC_IDLE;
            next_r.ready = 1'b0;
            next_r.trig_out = 1'b0;
        end
        // indicator: default green/red, or software colour
        // decoded from the next state so colour moves with ready;
        // an override needs one extra cycle to appear
        if (r.led[LED_OVR]) begin
            next_r.led_out = r.led[LED_COLOR_LSB +: 2];
        end else if (next_r.state == ATC_DONE) begin
            next_r.led_out = LED_RED;
        end else if (next_r.state == ATC_READY || next_r.state == ATC_VETO
            || next_r.state == ATC_OPEN) begin
            next_r.led_out = LED_GREEN;
        end else begin
            next_r.led_out = LED_OFF;
        end
    end

    // state register
    // constants only on reset; rate decade and running extremes
    // start at values other than zero
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            r <= '0;
            r.state <= ATC_IDLE;
            r.ctrl <= CTRL_RESET;
            r.rate_dec <= RATE_DEC_MAX;
            r.auto_min <= LEVEL_MAX;
            r.auto_max <= LEVEL_MIN;
        end else begin
            r <= next_r;
        end
    end

    // outputs are plain wires from the registered record
    assign o_rdata = r.rdata;
    assign o_trig_out = r.trig_out;
    assign o_acquisition_ready_out = r.ready;
    assign o_led = r.led_out;
    assign o_sample = r.sample;
    assign o_sample_valid = r.sample_valid;
    assign o_rate_mant = r.rate_mant;
    assign o_rate_dec = r.rate_dec;
endmodule : atc_trigger

// File: verif/atc_apparatus.sv
`timescale 1ns/1ps
module atc_apparatus (
    input wire logic i_clk,
    input wire logic i_ready,
    input wire logic i_fire,
    input wire logic i_early,
    input wire logic i_sel,
    output logic o_prep_a,
    output logic o_prep_b
);
    logic [1:0] left = 2'h0;
    // two-cycle prepare pulse so the pin synchroniser cannot miss it
    always_ff @(posedge i_clk) begin
        if (i_fire && (i_ready || i_early)) begin
            left <= 2'h2;
        end else if (left != 2'h0) begin
            left <= left - 2'h1;
        end
    end
    assign o_prep_a = (left != 2'h0) && !i_sel;
    assign o_prep_b = (left != 2'h0) && i_sel;
endmodule : atc_apparatus

// File: verif/atc_trigger_sva.sv
`timescale 1ns/1ps
module atc_chk
    import atc_pkg::*;
#(
    parameter int ACQ_CYCLES = ACQ_CYCLES_DEF
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic o_trig_out,
    input wire logic o_acquisition_ready_out,
    input wire logic [1:0] o_led,
    input wire logic o_sample_valid,
    input wire logic [2:0] o_rate_mant,
    input wire logic [3:0] o_rate_dec
);
    logic ovr;
    logic [1:0] col;
    logic [15:0] run;
    wire force_wr = i_wr && i_addr == ADDR_CMD && i_wdata[CMD_FORCE];
    // shadow of the colour override; run is the length of the sample burst
    always_ff @(posedge i_clk) begin
        if (i_reset || (i_wr && i_addr == ADDR_LED)) begin
            ovr <= !i_reset && i_wdata[LED_OVR];
            col <= i_wdata[LED_COLOR_LSB +: 2];
        end
        run <= (o_sample_valid && !i_reset) ? run + 16'h1 : 16'h0;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    a_trig_single: assert property (
        o_trig_out |=> !o_trig_out) else $error("trigger pulse too long");
    a_trig_ready: assert property (
        o_trig_out |-> $past(o_acquisition_ready_out)
        && !o_acquisition_ready_out) else $error("trigger without ready");
    a_ready_acq: assert property (
        o_sample_valid |-> !o_acquisition_ready_out) else $error("ready high");
    a_acq_length: assert property (
        $fell(o_sample_valid) |-> run == 16'(ACQ_CYCLES))
        else $error("acquisition length wrong");
    a_force_quiet: assert property (
        force_wr |=> !o_trig_out [*3]) else $error("pulse on forced trigger");
    a_led_green: assert property (
        !ovr && !$past(ovr) && o_acquisition_ready_out |-> o_led == LED_GREEN)
        else $error("led not green while waiting");
    a_led_red: assert property (
        $fell(o_sample_valid) && !ovr |-> ##[0:2] o_led == LED_RED)
        else $error("led not red after acquisition");
    a_led_override: assert property (
        ovr && $past(ovr) && $stable(col) |-> o_led == col)
        else $error("led ignores override");
    a_rate_legal: assert property (
        o_rate_mant <= RATE_MANT_MAX
        && o_rate_dec inside {[RATE_DEC_MIN:RATE_DEC_MAX]})
        else $error("rate setting out of range");
    c_trig: cover property (o_trig_out);
    c_acq: cover property ($fell(o_sample_valid));
    c_ovr: cover property (ovr && o_led == LED_RED);
endmodule : atc_chk
bind atc_trigger atc_chk #(.ACQ_CYCLES(ACQ_CYCLES)) i_chk (
    .i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .o_trig_out(o_trig_out),
    .o_acquisition_ready_out(o_acquisition_ready_out), .o_led(o_led),
    .o_sample_valid(o_sample_valid), .o_rate_mant(o_rate_mant),
    .o_rate_dec(o_rate_dec));

// File: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
    import atc_pkg::*;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [3:0] i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] src [3] = '{3{8'h9c}};
    logic fire = 1'b0;
    logic early = 1'b0;
    logic sel = 1'b0;
    logic i_prep_a, i_prep_b, o_trig_out, o_rdy, o_sample_valid;
    logic [31:0] o_rdata;
    logic [1:0] o_led;
    logic [7:0] o_sample;
    logic [2:0] o_rate_mant;
    logic [3:0] o_rate_dec;
    int errors = 0;
    int total_checks = 0;
    int trig_n = 0;
    int val_n = 0;
    int min_n = 0;
    always #10 i_clk = ~i_clk;
    atc_trigger #(.ACQ_CYCLES(8)) i_dut (
        .i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ch0(src[0]),
        .i_ch1(src[1]), .i_ext(src[2]), .i_prep_a(i_prep_a),
        .i_prep_b(i_prep_b), .o_trig_out(o_trig_out),
        .o_acquisition_ready_out(o_rdy), .o_led(o_led), .o_sample(o_sample),
        .o_sample_valid(o_sample_valid), .o_rate_mant(o_rate_mant),
        .o_rate_dec(o_rate_dec));
    atc_apparatus i_app (.i_clk(i_clk), .i_ready(o_rdy), .i_fire(fire),
        .i_early(early), .i_sel(sel), .o_prep_a(i_prep_a),
        .o_prep_b(i_prep_b));
    // event counters; checks compare them at the falling edge to avoid races
    always @(posedge i_clk) begin
        trig_n += int'(o_trig_out === 1'b1);
        val_n += int'(o_sample_valid === 1'b1);
        min_n += int'(o_sample_valid === 1'b1 && o_sample === SAMPLE_MIN_CODE);
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask : tick
    // bus cycles; strobes drop with a free cycle before the next one
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        tick(1);
        i_wr <= 1'b0;
        tick(1);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] m,
            input logic [31:0] exp);
        i_addr <= a;
        i_rd <= 1'b1;
        tick(1);
        i_rd <= 1'b0;
        @(negedge i_clk);
        check(o_rdata & m, exp);
        tick(1);
    endtask : rd
    // arm, swing the other sources then source s from a to b, judge
    task automatic round(input int s, input logic [31:0] ctrl,
            input logic [31:0] lvl, input logic [7:0] a, input logic [7:0] b,
            input logic exp);
        int t0 = trig_n;
        int v0 = val_n;
        for (int k = 0; k < 3; k++) src[k] <= a;
        wr(ADDR_LEVEL, lvl);
        wr(ADDR_CTRL, ctrl);
        wr(ADDR_CMD, 32'h1);
        for (int k = 0; k < 3; k++) if (k != s) src[k] <= b;
        tick(4);
        src[s] <= b;
        tick(16);
        @(negedge i_clk);
        check(trig_n - t0, 32'(exp));
        check(val_n - v0, exp ? 8 : 0);
        check(o_led, exp ? LED_RED : LED_GREEN);
        tick(1);
        wr(ADDR_CMD, exp ? 32'h4 : 32'h8);
    endtask : round
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim
    initial begin
        int n;
        int t0;
        int v0;
        int w0;
        logic [7:0] lv;
        void'($urandom(3613));
        tick(20);
        i_reset <= 1'b0;
        tick(1);
        rd(ADDR_CTRL, 32'hffffffff, CTRL_RESET);
        rd(4'hf, 32'hffffffff, 32'h0);
        check(o_rate_dec, RATE_DEC_MAX);
        $display("test reset done");
        // every source and both slopes at a random level
        for (int s = 0; s < 6; s++) begin
            lv = 8'($urandom_range(100)) - 8'h32;
            round(s / 2, ((s % 2) << CTRL_NEG) | (s / 2), {24'h0, lv},
                s % 2 ? lv + 8'h28 : lv - 8'h28,
                s % 2 ? lv - 8'h28 : lv + 8'h28, 1'b1);
        end
        // window exit and entry, each swung both ways
        for (int w = 0; w < 4; w++) begin
            round(0, 32'h20 | ((w / 2) << CTRL_WIN_ENTER), 32'h14ec,
                w % 2 ? 8'h64 : 8'h00, w % 2 ? 8'h00 : 8'h64, w / 2 == w % 2);
        end
        $display("test edges done");
        // couplings and external scale; hf drops slope and window
        for (int c = 0; c < 4; c++) begin
            w0 = c * 32'h804 + (c < 3 ? 32'h30 : 0);
            wr(ADDR_CTRL, (c << CTRL_CPL_LSB) | (c << CTRL_EXTFS_LSB)
                | 32'h30);
            rd(ADDR_CTRL, 32'h183c, w0);
        end
        // hf on the external input: after a trigger three edges stay quiet
        src[2] <= 8'hc0;
        wr(ADDR_LEVEL, 32'h0);
        wr(ADDR_CTRL, {28'h0, CPL_HF, SRC_EXT});
        for (int r = 0; r < 2; r++) begin
            wr(ADDR_CMD, 32'h1);
            t0 = trig_n;
            for (n = 0; n < 8; n++) begin
                src[2] <= 8'h40;
                tick(2);
                src[2] <= 8'hc0;
                tick(3);
                @(negedge i_clk);
                if (trig_n != t0) break;
                tick(1);
            end
            tick(12);
            if (r == 1) check(n, 3);
            wr(ADDR_CMD, 32'h4);
        end
        // software trigger: samples but no hardware pulse
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_CMD, 32'h1);
        t0 = trig_n;
        v0 = val_n;
        wr(ADDR_CMD, 32'h2);
        tick(16);
        @(negedge i_clk);
        check(trig_n - t0, 0);
        check(val_n - v0, 8);
        tick(1);
        wr(ADDR_CMD, 32'h4);
        // colour override while armed, then back to default
        wr(ADDR_LED, 32'h5);
        wr(ADDR_CMD, 32'h1);
        @(negedge i_clk);
        check(o_led, LED_RED);
        tick(1);
        wr(ADDR_LED, 32'h0);
        @(negedge i_clk);
        check(o_led, LED_GREEN);
        tick(1);
        wr(ADDR_CMD, 32'h8);
        $display("test modes done");
        // buffered: early prepare refused, veto, real trigger or timeout
        wr(ADDR_VETO, 32'h14);
        wr(ADDR_TIMEOUT, 32'h14);
        for (int p = 0; p < 2; p++) begin
            src[0] <= 8'h9c;
            sel <= p[0];
            early <= (p == 0);
            fire <= 1'b1;
            wr(ADDR_CTRL, 32'h180 | (p << CTRL_PREP_SEL));
            fire <= 1'b0;
            early <= 1'b0;
            tick(6);
            wr(ADDR_CMD, 32'h1);
            rd(ADDR_STATUS, 32'h1f, 32'h1);
            t0 = trig_n;
            v0 = val_n;
            w0 = min_n;
            fire <= 1'b1;
            tick(1);
            fire <= 1'b0;
            for (n = 0; n < 300; n++) begin
                if (p == 0) src[0] <= (n == 8 || n >= 45) ? 8'h64 : 8'h9c;
                @(negedge i_clk);
                if (val_n != v0) break;
                tick(1);
            end
            // veto and timeout are 20 steps of 30 ns, 30 cycles each
            if (p == 0) check(n >= 45 && n < 56, 1);
            else check(n >= 60 && n <= 72, 1);
            tick(12);
            @(negedge i_clk);
            check(trig_n - t0, 32'(p == 0));
            check(val_n - v0, 8);
            check(min_n - w0, p * 8);
            tick(1);
            wr(ADDR_CMD, 32'h4);
        end
        $display("test veto done");
        // random legal rates, each followed by a refused one
        for (int i = 0; i < 6; i++) begin
            n = $urandom_range(4);
            t0 = $urandom_range(9, 2);
            wr(ADDR_RATE, (t0 << 4) | n);
            wr(ADDR_RATE, i % 2 ? 32'h95 : 32'h13);
            check({o_rate_dec, o_rate_mant}, (t0 << 3) | n);
        end
        $display("test rate done");
        end_sim();
    end
    // hang guard, far beyond the several hundred cycles of the tests
    initial begin
        tick(50000);
        errors++;
        end_sim();
    end
endmodule : testbench
